// >>> core/or_move_pointer_load_exec.v
// execute block for or-literal, or-file, copy-file and pointer load
`timescale 1ns/1ps
`include "or_move_pointer_load_exec_defs.vh"

module or_move_pointer_load_exec (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // instruction stream
  input  wire        instr_valid,
  input  wire [15:0] instr_word,
  output reg         instr_ready_q,
  // mode and banking
  input  wire        ext_set_en,
  input  wire [3:0]  bank_select_register,
  // data memory, rdata valid while mem_rd_q is high
  output reg  [11:0] mem_addr_q,
  output reg         mem_rd_q,
  input  wire [7:0]  mem_rdata,
  output reg         mem_wr_q,
  output reg  [7:0]  mem_wdata_q,
  // architectural state
  output reg  [7:0]  acc_q,
  output reg         neg_q,
  output reg         zero_q,
  output reg  [11:0] ptr0_q,
  output reg  [11:0] ptr1_q,
  output reg  [11:0] ptr2_q
);

  localparam S_IDLE = 2'h0;
  localparam S_READ = 2'h1;
  localparam S_LIT2 = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  reg  [1:0]  state_q;
  reg         is_or_q;
  reg         dest_q;
  reg  [1:0]  ptr_sel_q;
  reg  [11:0] file_addr;
  reg  [7:0]  result;
  wire [7:0]  lit;
  wire [7:0]  op_hi;
  wire        take;
  wire        dec_or_lit;
  wire        dec_or_file;
  wire        dec_copy;
  wire        dec_ptr;
  wire [1:0]  dec_ptr_idx;
  wire [7:0]  lit_result;
  reg  [7:0]  acc_d;
  reg         neg_d;
  reg         zero_d;
  reg  [2:0]  ptr_hi_we;
  reg  [2:0]  ptr_lo_we;

  assign lit   = instr_word[7:0];
  assign op_hi = instr_word[15:8];
  assign take  = instr_valid & instr_ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // opcode decode, one flag per instruction family
  assign dec_or_lit  = (op_hi == `OP_OR_LIT);
  assign dec_or_file = (op_hi[7:2] == `OP_OR_FILE);
  assign dec_copy    = (op_hi[7:2] == `OP_COPY_FILE);
  assign dec_ptr_idx = instr_word[5:4];
  // index 3 is refused here so the pointer writes below never see it
  assign dec_ptr     = (op_hi == `OP_PTR_LOAD) && (instr_word[7:6] == `PTR_LOAD_SEL) &&
                       (dec_ptr_idx < `PTR_COUNT);
  assign lit_result  = acc_q | lit;

  // file address formation
  always @* begin
    if (ext_set_en && !instr_word[`BIT_ACCESS] && lit <= `INDEX_LIMIT) begin
      file_addr = ptr2_q + {4'h0, lit};
    end else if (instr_word[`BIT_ACCESS]) begin
      file_addr = {bank_select_register, lit};
    end else if (lit < `ACCESS_SPLIT) begin
      file_addr = {4'h0, lit};
    end else begin
      file_addr = {`ACCESS_HI_BANK, lit};
    end
  end

  // result of the file-side operation
  always @* begin
    if (is_or_q) begin
      result = acc_q | mem_rdata;
    end else begin
      result = mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next accumulator and flags; no other status bit lives here
  always @* begin
    acc_d  = acc_q;
    neg_d  = neg_q;
    zero_d = zero_q;
    if (state_q == S_IDLE && take && dec_or_lit) begin
      acc_d  = lit_result;
      neg_d  = lit_result[7];
      zero_d = (lit_result == 8'h00);
    end else if (state_q == S_READ) begin
      if (!dest_q) begin
        acc_d = result;
      end
      // flags follow the result even when it goes back to memory
      neg_d  = result[7];
      zero_d = (result == 8'h00);
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      acc_q  <= `ACC_RESET;
      neg_q  <= 1'b0;
      zero_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      neg_q  <= neg_d;
      zero_q <= zero_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pointer byte enables: high nibble on first word, low byte on second
  always @* begin
    ptr_hi_we = 3'h0;
    ptr_lo_we = 3'h0;
    if (state_q == S_IDLE && take && dec_ptr) begin
      ptr_hi_we[dec_ptr_idx] = 1'b1;
    end
    if (state_q == S_LIT2 && take) begin
      ptr_lo_we[ptr_sel_q] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      ptr0_q <= `PTR_RESET;
      ptr1_q <= `PTR_RESET;
      ptr2_q <= `PTR_RESET;
    end else begin
      if (ptr_hi_we[0]) begin
        ptr0_q[11:8] <= instr_word[3:0];
      end
      if (ptr_hi_we[1]) begin
        ptr1_q[11:8] <= instr_word[3:0];
      end
      if (ptr_hi_we[2]) begin
        ptr2_q[11:8] <= instr_word[3:0];
      end
      if (ptr_lo_we[0]) begin
        ptr0_q[7:0] <= lit;
      end
      if (ptr_lo_we[1]) begin
        ptr1_q[7:0] <= lit;
      end
      if (ptr_lo_we[2]) begin
        ptr2_q[7:0] <= lit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (!rst_n) begin
      state_q       <= S_IDLE;
      instr_ready_q <= 1'b0;
      is_or_q       <= 1'b0;
      dest_q        <= 1'b0;
      ptr_sel_q     <= 2'h0;
      mem_addr_q    <= 12'h000;
      mem_rd_q      <= 1'b0;
      mem_wr_q      <= 1'b0;
      mem_wdata_q   <= 8'h00;
    end else begin
      mem_wr_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          instr_ready_q <= 1'b1;
          if (take) begin
            if (dec_or_file || dec_copy) begin
              // file ops spend a second clock reading the operand
              is_or_q       <= (op_hi[7:2] == `OP_OR_FILE);
              dest_q        <= instr_word[`BIT_DEST];
              mem_addr_q    <= file_addr;
              mem_rd_q      <= 1'b1;
              instr_ready_q <= 1'b0;
              state_q       <= S_READ;
            end else if (dec_ptr) begin
              ptr_sel_q <= dec_ptr_idx;
              state_q   <= S_LIT2;
            end
            // other opcodes belong to other units and are consumed silently
          end
        end
        S_READ: begin
          mem_rd_q <= 1'b0;
          if (dest_q) begin
            mem_wr_q    <= 1'b1;
            mem_wdata_q <= result;
          end
          instr_ready_q <= 1'b1;
          state_q       <= S_IDLE;
        end
        S_LIT2: begin
          // the word after the first is taken as the literal low byte
          if (take) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          mem_rd_q      <= 1'b0;
          instr_ready_q <= 1'b1;
          state_q       <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> shared/or_move_pointer_load_exec_defs.vh
// constants for the or / copy / pointer-load execute block
// Functional notes
// - upper byte 0000 1001 decodes as OR literal into accumulator
// - accumulator ORed with 8-bit literal, result back to accumulator, one word
// - both ORs and the file copy touch only negative and zero flags
// - top bits 0001 00 decode as OR accumulator with file, then d, a, address
// - OR result goes to accumulator when d is 0, file when d is 1
// - access bit 0 uses access bank, 1 uses bank select register
// - extended set, access bit 0, address up to 5Fh: indexed literal offset
// - pointer load writes 12-bit literal to pointer 0..2, two words
// - top bits 0101 00 decode as file copy with d, a, 8-bit address
// - file copy goes to accumulator when d is 0, back to file when 1
`ifndef OR_MOVE_POINTER_LOAD_EXEC_DEFS_VH
`define OR_MOVE_POINTER_LOAD_EXEC_DEFS_VH

`define OP_OR_LIT      8'h09
`define OP_OR_FILE     6'h04
`define OP_COPY_FILE   6'h14
`define OP_PTR_LOAD    8'hee
`define PTR_LOAD_SEL   2'h0
`define PTR_SECOND     8'hf0
`define PTR_COUNT      2'h3
`define ACCESS_SPLIT   8'h80
`define ACCESS_HI_BANK 4'hf
`define INDEX_LIMIT    8'h5f
`define INDEX_PTR      2
`define BIT_DEST       9
`define BIT_ACCESS     8
`define ACC_RESET      8'h00
`define PTR_RESET      12'h000

`endif

// >>> verif/or_exec_sva.sv
// checker for the or / copy / pointer-load execute block
`timescale 1ns/1ps
module or_exec_sva (
  input logic clk, rst_n, instr_valid, instr_ready_q, ext_set_en,
  input logic mem_rd_q, mem_wr_q, neg_q, zero_q,
  input logic [15:0] instr_word,
  input logic [3:0] bank_select_register,
  input logic [11:0] mem_addr_q, ptr0_q, ptr1_q, ptr2_q,
  input logic [7:0] mem_rdata, mem_wdata_q, acc_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire tk = instr_valid && instr_ready_q;
  wire [7:0] f = instr_word[7:0];
  wire fop = tk && (instr_word[15:10] == 6'h04 || instr_word[15:10] == 6'h14);
  sequence s_lit; tk && instr_word[15:8] == 8'h09; endsequence
  sequence s_orf; tk && instr_word[15:9] == 7'h09 ##1 mem_rd_q; endsequence
  sequence s_cpy; tk && instr_word[15:9] == 7'h28 ##1 mem_rd_q; endsequence
  chk_lit_res: assert property (s_lit |=> acc_q == ($past(acc_q) | $past(f)))
    else $error("or literal result wrong");
  chk_lit_flags: assert property (s_lit |=> neg_q == acc_q[7] && zero_q == !acc_q)
    else $error("or literal flags wrong");
  chk_file_read: assert property (fop |=> mem_rd_q && !instr_ready_q)
    else $error("file read missing");
  chk_orf_write: assert property (s_orf |=> mem_wr_q && mem_wdata_q == ($past(acc_q) | $past(mem_rdata)))
    else $error("or file write wrong");
  chk_wr_flags: assert property (mem_wr_q |-> neg_q == mem_wdata_q[7] && zero_q == !mem_wdata_q)
    else $error("write flags wrong");
  chk_copy_acc: assert property (s_cpy |=> !mem_wr_q && acc_q == $past(mem_rdata))
    else $error("copy to accumulator wrong");
  chk_index_addr: assert property (fop && !instr_word[8] && ext_set_en && f <= 8'h5f
    |=> mem_addr_q == $past(ptr2_q) + $past(f)) else $error("indexed address wrong");
  chk_ptr_high: assert property (tk && instr_word[15:4] == 12'hee2
    |=> ptr2_q[11:8] == $past(instr_word[3:0])) else $error("pointer high wrong");
endmodule
bind or_move_pointer_load_exec or_exec_sva chk (.*);

// >>> verif/tb.sv
// random and corner testbench for the execute block
`timescale 1ns/1ps
module tb;
  reg clk = 0, rst_n = 0, instr_valid = 0, ext_set_en = 1, en = 0, ez = 0;
  reg [15:0] instr_word = 16'h0000;
  reg [3:0] bank_select_register = 4'h0;
  wire instr_ready_q, mem_rd_q, mem_wr_q, neg_q, zero_q;
  wire [11:0] mem_addr_q, ptr0_q, ptr1_q, ptr2_q, ep[0:2];
  wire [7:0] mem_rdata, mem_wdata_q, acc_q;
  reg [7:0] mem[0:4095], rm[0:4095], ea = 8'h00, v;
  reg [11:0] p[0:3], a;
  reg [31:0] s = 70818, r;
  integer fails = 0, check_count = 0, i, k;
  assign ep[0] = ptr0_q, ep[1] = ptr1_q, ep[2] = ptr2_q;
  always #12.5 clk = ~clk;
  // released bus shows inverted data so a stale read cannot pass
  assign mem_rdata = mem_rd_q ? mem[mem_addr_q] : ~mem[mem_addr_q];
  always @(posedge clk) if (mem_wr_q) mem[mem_addr_q] <= mem_wdata_q;
  or_move_pointer_load_exec uut (.*);
  function [31:0] xs();
    s = s ^ (s << 13); s = s ^ (s >> 17); s = s ^ (s << 5); xs = s;
  endfunction
  task close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input [8*4:1] n, input [11:0] e, g);
    check_count++;
    if (g !== e) begin fails++; $display("MISMATCH %0s exp %h got %h", n, e, g); end
  endtask
  task put(input [15:0] w);
    for (i = 0; i < 9 && instr_ready_q !== 1'b1; i++) @(negedge clk);
    if (i == 9) begin fails++; close_out; end
    if (ext_set_en && !w[8] && w[7:0] <= 8'h5f) a = p[2] + w[7:0];
    else a = w[8] ? {bank_select_register, w[7:0]} : {{4{w[7]}}, w[7:0]};
    v = w[14] ? rm[a] : ea | (w[12] ? rm[a] : w[7:0]);
    if (w[15:8] == 8'h09 || w[15:10] == 6'h04 || w[15:10] == 6'h14) begin
      if (w[12] && w[9]) rm[a] = v; else ea = v;
      en = v[7]; ez = !v;
    end
    instr_valid = 1; instr_word = w;
    @(negedge clk);
  endtask
  task ld(input [1:0] x, input [11:0] kk);
    put({10'h3b8, x, kk[11:8]}); put({8'hf0, kk[7:0]});
    if (x != 3) p[x] = kk;
  endtask
  task settle;
    instr_valid = 0; repeat (3) @(negedge clk);
    chk("acc", ea, acc_q);
    chk("neg", en, neg_q); chk("zero", ez, zero_q);
    for (i = 0; i < 3; i++) chk("ptr", p[i], ep[i]);
    for (i = 0; i < 4096; i++) chk("mem", rm[i], mem[i]);
  endtask
  initial begin
    for (i = 0; i < 4096; i++) begin r = xs(); mem[i] = r; rm[i] = r; end
    for (i = 0; i < 4; i++) p[i] = 0;
    mem[96] = 0; rm[96] = 0;
    repeat (6) @(negedge clk);
    rst_n = 1;
    put(16'h099a); put(16'h0935); ld(2, 12'h3ab); ld(3, 12'h123);
    put(16'h505f); put(16'h5060); put(16'h1360);
    settle; $display("corner test done");
    for (k = 0; k < 20; k++) begin
      r = xs(); ext_set_en = r[0]; bank_select_register = r[4:1];
      repeat (12) begin
        r = xs();
        case (r[1:0])
          0: put({8'h09, r[15:8]});
          1: put({6'h04, r[17:8]});
          2: put({6'h14, r[17:8]});
          default: ld(r[9:8], r[27:16]);
        endcase
      end
      settle; $display("random test %0d done", k);
    end
    close_out;
  end
endmodule
